// file: core/vpmb_core.sv
/*
 * Variable precision multiply block: request pipeline, two wide multipliers, three
 * narrow ones, sum/chain/accumulate path and the result FIFO.
 * Assumes user fabric on clk drives requests with valid/ready and drains results.
 */
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module vpmb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    // Entries held, output stage included
    output logic [vpmb_pkg::LEVEL_W-1:0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic outValid_reg;
    logic [WIDTH-1:0] outData_reg;

    wire logic push = inValid && inReady;
    wire logic outFree = !outValid_reg || outReady;
    wire logic pop = outFree && (count_reg != '0);
    wire logic [AW:0] countNext = count_reg + (AW + 1)'(push) - (AW + 1)'(pop);

    assign inReady = (count_reg != (AW + 1)'(DEPTH));
    assign outValid = outValid_reg;
    assign outData = outData_reg;
    assign level = vpmb_pkg::LEVEL_W'(count_reg) + vpmb_pkg::LEVEL_W'(outValid_reg);

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            outValid_reg <= 1'b0;
            outData_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_reg + AW'(push);
            rdPtr_reg <= rdPtr_reg + AW'(pop);
            count_reg <= countNext;
            if (outFree) begin
                outValid_reg <= pop;
            end
            if (pop) begin
                outData_reg <= mem_reg[rdPtr_reg];
            end
        end
    end
endmodule // vpmb_fifo

////////////////////////////////////////////////////////////////////////////////
module vpmb_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request from fabric
    input wire logic reqValid,
    output logic reqReady,
    input wire vpmb_pkg::vpmb_req_s req,
    // Result to fabric
    output logic resValid,
    input wire logic resReady,
    output vpmb_pkg::vpmb_res_s res
);
    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Extends a w-bit operand to 28 bits, sign or zero as asked
    function automatic logic signed [27:0] extOp(input logic [26:0] v, input logic [4:0] w, input logic s);
        logic [27:0] r;
        r = '0;
        for (int i = 0; i < 28; i++) begin
            if (i < int'(w)) begin
                r[i] = v[i];
            end else begin
                r[i] = s & v[w - 5'h1];
            end
        end
        return signed'(r);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Input register stage

    logic reqReady_reg;
    logic s1Valid_reg;
    vpmb_pkg::vpmb_req_s s1Req_reg;
    logic [vpmb_pkg::OP_W-1:0] sysXIn_reg;

    wire logic take = reqValid && reqReady_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1Valid_reg <= 1'b0;
            s1Req_reg <= '0;
            sysXIn_reg <= '0;
        end else begin
            s1Valid_reg <= take;
            if (take) begin
                s1Req_reg <= req;
                sysXIn_reg <= s1Req_reg.xOperandPort;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decode

    vpmb_pkg::vpmb_mode_e mode;
    assign mode = s1Req_reg.mode;

    wire logic isSys18 = (mode == vpmb_pkg::MODE_SYS18);
    wire logic isSys27 = (mode == vpmb_pkg::MODE_SYS27);
    wire logic isSys = isSys18 || isSys27;
    wire logic is18x19Fam = (mode == vpmb_pkg::MODE_18X19) || (mode == vpmb_pkg::MODE_CPLX_IMAG)
        || (mode == vpmb_pkg::MODE_CPLX_REAL) || (mode == vpmb_pkg::MODE_SUM2_18)
        || (mode == vpmb_pkg::MODE_SUM4_18);
    wire logic is27Fam = (mode == vpmb_pkg::MODE_27X27) || (mode == vpmb_pkg::MODE_SUM2_27) || isSys27;
    wire logic is18x18Top = (mode == vpmb_pkg::MODE_18X18) || (mode == vpmb_pkg::MODE_PLUS36) || isSys18;
    wire logic isDual = (mode == vpmb_pkg::MODE_18X18) || (mode == vpmb_pkg::MODE_18X19);
    wire logic is52 = (mode == vpmb_pkg::MODE_18X25) || (mode == vpmb_pkg::MODE_20X24);
    wire logic usesBot = is18x19Fam || isSys18;

    // Operand widths of the upper multiplier, and the y width of the lower one
    wire logic [4:0] topWa = (mode == vpmb_pkg::MODE_20X24) ? vpmb_pkg::W20 :
        is27Fam ? vpmb_pkg::W27 : vpmb_pkg::W18;
    wire logic [4:0] topWb = (mode == vpmb_pkg::MODE_18X25) ? vpmb_pkg::W25 :
        (mode == vpmb_pkg::MODE_20X24) ? vpmb_pkg::W24 :
        is27Fam ? vpmb_pkg::W27 :
        is18x19Fam ? vpmb_pkg::W19 : vpmb_pkg::W18;
    wire logic [4:0] botWb = is18x19Fam ? vpmb_pkg::W19 : vpmb_pkg::W18;

    // y sign: fixed unsigned at 18x18 and 18x18 plus 36, fixed signed in the 18x19 family (18x19, complex, 18-bit sums), free elsewhere
    wire logic topYSigned = is18x19Fam ? 1'b1 :
        ((mode == vpmb_pkg::MODE_18X18) || (mode == vpmb_pkg::MODE_PLUS36)) ? 1'b0 :
        s1Req_reg.ySigned;
    wire logic botYSigned = is18x19Fam ? 1'b1 : isSys18 ? s1Req_reg.ySigned : 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Systolic operand selection

    wire logic [26:0] preTop = s1Req_reg.yOperandPort + s1Req_reg.zOperand;
    wire logic [18:0] preBot = s1Req_reg.lowerYOperandBus[18:0] + s1Req_reg.zBot;
    wire logic [26:0] dynBotX = {9'h0_00, s1Req_reg.xBot};
    wire logic [26:0] dynBotY = {8'h00, s1Req_reg.lowerYOperandBus[18:0]};
    wire logic [1:0] src = isSys ? s1Req_reg.srcSel : vpmb_pkg::SRC_DYN_DYN;

    wire logic [26:0] topA = (src == vpmb_pkg::SRC_COEF_PRE) ? s1Req_reg.coefTop : s1Req_reg.xOperandPort;
    wire logic [26:0] topB = (src == vpmb_pkg::SRC_DYN_DYN) ? s1Req_reg.yOperandPort :
        (src == vpmb_pkg::SRC_DYN_COEF) ? s1Req_reg.coefTop : preTop;
    wire logic [26:0] botA = (src == vpmb_pkg::SRC_COEF_PRE) ? {8'h00, s1Req_reg.coefBot} : dynBotX;
    wire logic [26:0] botB = (src == vpmb_pkg::SRC_DYN_DYN) ? dynBotY :
        (src == vpmb_pkg::SRC_DYN_COEF) ? {8'h00, s1Req_reg.coefBot} : {8'h00, preBot};

    ////////////////////////////////////////////////////////////////////////////////
    // Multipliers

    wire logic signed [55:0] pTop = extOp(topA, topWa, s1Req_reg.xSigned) * extOp(topB, topWb, topYSigned);
    // Lower product is forced to zero when the mode leaves the lower multiplier unused; its operands are not gated
    wire logic signed [55:0] pBot = usesBot || isDual ?
        extOp(botA, vpmb_pkg::W18, s1Req_reg.xSigned) * extOp(botB, botWb, botYSigned) : 56'sh0;

    // Three narrow products from packed operands
    logic [vpmb_pkg::P9_W*3-1:0] p9;
    for (genvar i = 0; i < 3; i++) begin : gNarrow
        wire logic [8:0] a9 = s1Req_reg.xOperandPort[i*9 +: 9];
        wire logic [8:0] b9 = s1Req_reg.yOperandPort[i*9 +: 9];
        wire logic signed [9:0] a9x = {s1Req_reg.xSigned & a9[8], a9};
        wire logic signed [9:0] b9x = {s1Req_reg.ySigned & b9[8], b9};
        wire logic signed [19:0] prod = a9x * b9x;
        assign p9[i*vpmb_pkg::P9_W +: vpmb_pkg::P9_W] = prod[17:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sum, chain and accumulate

    logic [vpmb_pkg::CHAIN_W-1:0] acc_reg;

    wire logic [63:0] pTop64 = 64'(pTop);
    wire logic [63:0] pBot64 = 64'(pBot);
    wire logic [63:0] lowY64 = {28'h000_0000, s1Req_reg.lowerYOperandBus};
    wire logic [63:0] base = (mode == vpmb_pkg::MODE_PLUS36) ? pTop64 + lowY64 :
        (mode == vpmb_pkg::MODE_CPLX_REAL) ? pTop64 - pBot64 :
        usesBot ? pTop64 + pBot64 : pTop64;
    wire logic [63:0] chainTerm = s1Req_reg.chainEn ? s1Req_reg.chainIn : 64'h0000_0000_0000_0000;
    wire logic [63:0] accTerm = s1Req_reg.accEn ? acc_reg : 64'h0000_0000_0000_0000;
    wire logic [63:0] sumFull = base + chainTerm + accTerm;
    wire logic [63:0] sum52 = {12'h000, sumFull[vpmb_pkg::WIDE52_W-1:0]};
    wire logic [63:0] sum44 = {20'h0_0000, sumFull[vpmb_pkg::SYS18_W-1:0]};
    wire logic [63:0] sumKept = is52 ? sum52 : isSys18 ? sum44 : sumFull;

    // Independent products are packed side by side, no adder in between
    wire logic [vpmb_pkg::RES_W-1:0] dualRes = {pBot[36:0], pTop[36:0]};
    wire logic [vpmb_pkg::RES_W-1:0] narrowRes = {20'h0_0000, p9};
    wire logic [vpmb_pkg::RES_W-1:0] resultNext = (mode == vpmb_pkg::MODE_9X9) ? narrowRes :
        isDual ? dualRes : {10'h000, sumKept};

    ////////////////////////////////////////////////////////////////////////////////
    // Output register bank

    logic s2Valid_reg;
    vpmb_pkg::vpmb_res_s s2Res_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            s2Valid_reg <= 1'b0;
            s2Res_reg <= '0;
            acc_reg <= '0;
        end else begin
            s2Valid_reg <= s1Valid_reg;
            if (s1Valid_reg) begin
                s2Res_reg.result <= resultNext;
                s2Res_reg.sysXOut <= sysXIn_reg;
                acc_reg <= sumKept;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Result FIFO and admission

    logic [vpmb_pkg::LEVEL_W-1:0] fifoLevel;
    logic fifoInReady;

    vpmb_fifo #(
        .WIDTH($bits(vpmb_pkg::vpmb_res_s)),
        .DEPTH(vpmb_pkg::FIFO_DEPTH)
    ) uFifo (
        .clk(clk),
        .rst(rst),
        .inValid(s2Valid_reg),
        .inReady(fifoInReady),
        .inData(s2Res_reg),
        .outValid(resValid),
        .outReady(resReady),
        .outData(res),
        .level(fifoLevel)
    );

    // Pipeline never stalls, so admission reserves room for everything in flight
    wire logic [5:0] used = 6'(fifoLevel) + 6'(s1Valid_reg) + 6'(s2Valid_reg) + 6'(take);
    wire logic readyNext = (used <= vpmb_pkg::READY_LIMIT);

    always_ff @(posedge clk) begin
        if (rst) begin
            reqReady_reg <= 1'b0;
        end else begin
            reqReady_reg <= readyNext && fifoInReady;
        end
    end

    assign reqReady = reqReady_reg;
endmodule // vpmb_core

// file: core/vpmb_pkg.sv
/*
 * Shared widths, modes and carrier structs of the variable precision multiply block.
 * Assumes a single clock domain; every user of these names writes vpmb_pkg::name.
 */
package vpmb_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int OP_W = 27;
    localparam int BOT_X_W = 18;
    localparam int BOT_Y_W = 19;
    localparam int LOW_Y_W = 36;
    localparam int CHAIN_W = 64;
    localparam int RES_W = 74;
    localparam int NARROW_W = 9;
    localparam int P9_W = 18;
    localparam int P37_W = 37;
    localparam int SYS18_W = 44;
    localparam int WIDE52_W = 52;
    localparam int FIFO_DEPTH = 16;
    localparam int LEVEL_W = 5;

    // Operand widths per precision
    localparam logic [4:0] W18 = 5'h12;
    localparam logic [4:0] W19 = 5'h13;
    localparam logic [4:0] W20 = 5'h14;
    localparam logic [4:0] W24 = 5'h18;
    localparam logic [4:0] W25 = 5'h19;
    localparam logic [4:0] W27 = 5'h1b;

    // Systolic source pairs
    localparam logic [1:0] SRC_DYN_DYN = 2'h0;
    localparam logic [1:0] SRC_DYN_COEF = 2'h1;
    localparam logic [1:0] SRC_COEF_PRE = 2'h2;
    localparam logic [1:0] SRC_DYN_PRE = 2'h3;

    // Highest count of held results plus requests in flight at which admission stays open
    localparam logic [5:0] READY_LIMIT = 6'h0e;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [3:0] {
        MODE_9X9, MODE_18X18, MODE_18X19, MODE_18X25, MODE_20X24, MODE_27X27,
        MODE_CPLX_IMAG, MODE_CPLX_REAL, MODE_SUM2_18, MODE_SUM2_27, MODE_SUM4_18,
        MODE_PLUS36, MODE_SYS18, MODE_SYS27
    } vpmb_mode_e;

    typedef struct packed {
        vpmb_mode_e mode;
        logic xSigned;
        logic ySigned;
        logic accEn;
        logic chainEn;
        logic [1:0] srcSel;
        logic [OP_W-1:0] xOperandPort;
        logic [OP_W-1:0] yOperandPort;
        logic [OP_W-1:0] zOperand;
        logic [OP_W-1:0] coefTop;
        logic [BOT_X_W-1:0] xBot;
        logic [LOW_Y_W-1:0] lowerYOperandBus;
        logic [BOT_Y_W-1:0] zBot;
        logic [BOT_Y_W-1:0] coefBot;
        logic [CHAIN_W-1:0] chainIn;
    } vpmb_req_s;

    typedef struct packed {
        logic [RES_W-1:0] result;
        logic [OP_W-1:0] sysXOut;
    } vpmb_res_s;

endpackage

// file: testbench/vpmb_core_sva.sv
/* Checker on the multiply block ports: reset, pairing, latency, hold, admission, result widths.
   Assumes it is bound to vpmb_core and sees only the ports of that module. */
`timescale 1ns/1ns
module vpmb_core_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request side
    input wire logic reqValid,
    input wire logic reqReady,
    input wire vpmb_pkg::vpmb_req_s req,
    // Result side
    input wire logic resValid,
    input wire logic resReady,
    input wire vpmb_pkg::vpmb_res_s res
);
    ////////////////////////////////////////
    // Modes of taken requests, read back in result order
    vpmb_pkg::vpmb_mode_e modeQ [0:31];
    // Signedness of x per taken request: an unsigned 18x18 product zero-extends instead
    logic sgnQ [0:31];
    logic [4:0] wrPtr_reg;
    logic [4:0] rdPtr_reg;
    wire logic take = reqValid && reqReady;
    wire logic [4:0] pending = wrPtr_reg - rdPtr_reg;
    wire vpmb_pkg::vpmb_mode_e head = modeQ[rdPtr_reg];
    always_ff @(posedge clk) begin
        if (take) begin
            modeQ[wrPtr_reg] <= req.mode;
            sgnQ[wrPtr_reg] <= req.xSigned;
        end
        wrPtr_reg <= rst ? 5'h00 : wrPtr_reg + 5'(take);
        rdPtr_reg <= rst ? 5'h00 : rdPtr_reg + 5'(resValid && resReady);
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_RESET_QUIET: assert property (disable iff (1'b0) $past(rst) && !rst |-> !reqReady && !resValid && res == '0)
        else $error("block active right after reset");
    AST_ONE_RESULT: assert property (resValid |-> pending != 5'h00)
        else $error("result without a pending request");
    AST_FIRST_RESULT: assert property (take && pending == 5'h00 && !resValid |=> !resValid ##1 !resValid ##[1:2] resValid)
        else $error("result latency out of range");
    AST_RES_HOLD: assert property (resValid && !resReady |=> resValid && $stable(res))
        else $error("result changed before it was taken");
    AST_ADMIT: assert property (pending >= 5'h13 |-> !reqReady)
        else $error("request admitted beyond buffer room");
    AST_WIDE_52: assert property (resValid && (head == vpmb_pkg::MODE_18X25 || head == vpmb_pkg::MODE_20X24)
        |-> res.result[63:52] == '0)
        else $error("wide result above 52 bits");
    AST_SYS18_44: assert property (resValid && head == vpmb_pkg::MODE_SYS18 |-> res.result[63:44] == '0)
        else $error("systolic sum above 44 bits");
    AST_EXT_36: assert property (resValid && head == vpmb_pkg::MODE_18X18
        |-> res.result[36] == (sgnQ[rdPtr_reg] & res.result[35])
        && res.result[73] == (sgnQ[rdPtr_reg] & res.result[72]))
        else $error("36-bit product not sign extended");
endmodule // vpmb_core_sva

// file: testbench/vpmb_sink.sv
/* Result consumer standing for the user fabric behind the multiply block.
   Assumes one shared clock; stall and slow pacing come from the testbench. */
`timescale 1ns/1ns
module vpmb_sink (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Result from the block
    input wire logic resValid,
    output logic resReady,
    input wire vpmb_pkg::vpmb_res_s res,
    // Pacing
    input wire logic stall,
    input wire logic slow,
    // Each taken result, one cycle later
    output logic gotValid,
    output vpmb_pkg::vpmb_res_s gotRes
);
    logic phase_reg;
    // Ready changes only after an edge; slow mode takes every other cycle
    always_ff @(posedge clk) begin
        gotValid <= !rst && resValid && resReady;
        gotRes <= res;
        phase_reg <= !rst && !phase_reg;
        resReady <= !rst && !stall && (!slow || phase_reg);
    end
endmodule // vpmb_sink

// file: testbench/testbench.sv
/* Testbench of the multiply block: sends requests per mode, checks each result in order.
   Assumes vpmb_core, vpmb_sink and vpmb_core_sva are compiled before it. */
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reqValid = 1'b0;
    logic reqReady;
    vpmb_pkg::vpmb_req_s req = '0;
    logic resValid;
    logic resReady;
    vpmb_pkg::vpmb_res_s res;
    logic stall = 1'b0;
    logic slow = 1'b0;
    logic gotValid;
    vpmb_pkg::vpmb_res_s gotRes;
    logic [73:0] expQ [$];
    int widthQ [$];
    logic [27:0] sysQ [$];
    int fails = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    vpmb_core i_vpmb_core (.clk(clk), .rst(rst), .reqValid(reqValid), .reqReady(reqReady), .req(req),
        .resValid(resValid), .resReady(resReady), .res(res));
    vpmb_sink i_vpmb_sink (.clk(clk), .rst(rst), .resValid(resValid), .resReady(resReady), .res(res),
        .stall(stall), .slow(slow), .gotValid(gotValid), .gotRes(gotRes));
    ////////////////////////////////////////
    task automatic check(input string what, input logic [73:0] e, input logic [73:0] s);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Results are judged in request order; width masks the bits that the mode defines
    always @(negedge clk) begin
        if (gotValid === 1'b1) begin
            if (expQ.size() == 0) begin
                check("unexpected result", 74'h0, 74'h1);
            end else begin
                check("result", expQ[0], gotRes.result & ({74{1'b1}} >> (74 - widthQ[0])));
                if (sysQ[0][27]) begin
                    check("sysXOut", 74'(sysQ[0][26:0]), 74'(gotRes.sysXOut));
                end
                void'(expQ.pop_front());
                void'(widthQ.pop_front());
                void'(sysQ.pop_front());
            end
        end
    end
    function automatic vpmb_pkg::vpmb_req_s mk(input vpmb_pkg::vpmb_mode_e m, input logic [26:0] x,
            input logic [26:0] y);
        vpmb_pkg::vpmb_req_s r;
        r = '0;
        r.mode = m;
        r.xOperandPort = x;
        r.yOperandPort = y;
        return r;
    endfunction
    // Entered at a falling edge; returns at the falling edge after the request was taken
    task automatic send(input vpmb_pkg::vpmb_req_s r, input logic [73:0] e, input int w, input logic [27:0] sx);
        int n;
        n = 0;
        expQ.push_back(e);
        widthQ.push_back(w);
        sysQ.push_back(sx);
        req = r;
        reqValid = 1'b1;
        while (reqReady !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        check("request taken", 74'h1, 74'(n < 500));
        @(negedge clk);
    endtask
    task automatic drain();
        int n;
        n = 0;
        reqValid = 1'b0;
        while (expQ.size() != 0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        repeat (2) @(negedge clk);
        check("resValid drained", 74'h0, 74'(resValid));
    endtask
    ////////////////////////////////////////
    task automatic t_indep();
        vpmb_pkg::vpmb_req_s r;
        send(mk(vpmb_pkg::MODE_9X9, {9'h1ff, 9'h0a5, 9'h003}, {9'h1ff, 9'h101, 9'h0ff}),
            74'({18'(511 * 511), 18'(165 * 257), 18'(3 * 255)}), 54, 28'h000_0000);
        r = mk(vpmb_pkg::MODE_18X19, 27'(18'h3fff0), 27'(19'h7fffd));
        r.xSigned = 1'b1;
        r.ySigned = 1'b1;
        r.xBot = 18'h00005;
        r.lowerYOperandBus = 36'(19'h40000);
        send(r, {37'(5 * -262144), 37'(48)}, 74, 28'h000_0000);
        r = mk(vpmb_pkg::MODE_18X18, 27'(18'h3fffe), 27'(18'h20000));
        r.xSigned = 1'b1;
        r.ySigned = 1'b1;
        r.xBot = 18'h00003;
        r.lowerYOperandBus = 36'(18'h3ffff);
        send(r, {37'(3 * 262143), 37'(-2 * 131072)}, 74, 28'h000_0000);
        drain();
    endtask
    task automatic t_wide();
        vpmb_pkg::vpmb_req_s r;
        logic [63:0] t;
        for (int i = 0; i < 2; i++) begin
            r = mk(i == 0 ? vpmb_pkg::MODE_18X25 : vpmb_pkg::MODE_20X24, 27'(18'h3ffff), 27'(24'hff_ffff));
            r.chainEn = 1'b1;
            r.chainIn = 64'h0010_0000_0000_0001;
            t = 64'(18'h3ffff) * 64'(24'hff_ffff) + 64'h1;
            send(r, 74'(t[51:0]), 64, 28'h000_0000);
        end
        r = mk(vpmb_pkg::MODE_27X27, 27'h7ff_ffff, 27'h7ff_ffff);
        r.chainEn = 1'b1;
        r.chainIn = 64'hffff_ffff_ffff_ffff;
        t = 64'(27'h7ff_ffff) * 64'(27'h7ff_ffff) - 64'h1;
        send(r, 74'(t), 64, 28'h000_0000);
        r = mk(vpmb_pkg::MODE_27X27, 27'h000_0002, 27'h000_0003);
        r.accEn = 1'b1;
        send(r, 74'(t + 64'h6), 64, 28'h000_0000);
        drain();
    endtask
    task automatic t_sums();
        vpmb_pkg::vpmb_req_s r;
        slow = 1'b1;
        r = mk(vpmb_pkg::MODE_CPLX_IMAG, 27'h3, 27'h5);
        r.xBot = 18'h00007;
        r.lowerYOperandBus = 36'hb;
        send(r, 74'h5c, 64, 28'h000_0000);
        r.mode = vpmb_pkg::MODE_CPLX_REAL;
        r.yOperandPort = 27'hb;
        r.lowerYOperandBus = 36'h5;
        send(r, 74'(64'hffff_ffff_ffff_fffe), 64, 28'h000_0000);
        r.mode = vpmb_pkg::MODE_SUM2_18;
        send(r, 74'h44, 64, 28'h000_0000);
        r.mode = vpmb_pkg::MODE_SUM4_18;
        r.chainEn = 1'b1;
        r.chainIn = 64'h64;
        send(r, 74'ha8, 64, 28'h000_0000);
        r = mk(vpmb_pkg::MODE_SUM2_27, 27'h3e8, 27'h3e8);
        r.chainEn = 1'b1;
        r.chainIn = 64'h5;
        send(r, 74'hf_4245, 64, 28'h000_0000);
        r = mk(vpmb_pkg::MODE_PLUS36, 27'h10, 27'h2_0000);
        r.ySigned = 1'b1;
        r.lowerYOperandBus = 36'hf_0000_0001;
        send(r, 74'hf_0020_0001, 64, 28'h000_0000);
        drain();
        slow = 1'b0;
    endtask
    task automatic t_sys();
        vpmb_pkg::vpmb_req_s r;
        logic [63:0] t;
        int e;
        for (int s = 0; s < 4; s++) begin
            r = mk(vpmb_pkg::MODE_SYS18, 27'(s + 2), 27'h3);
            r.srcSel = 2'(s);
            r.zOperand = 27'h4;
            r.coefTop = 27'h5;
            r.xBot = 18'h00006;
            r.lowerYOperandBus = 36'h7;
            r.zBot = 19'h8;
            r.coefBot = 19'h9;
            e = s == 0 ? (s + 2) * 3 + 42 : s == 1 ? (s + 2) * 5 + 54 : s == 2 ? 170 : (s + 2) * 7 + 90;
            send(r, 74'(e), 64, {1'b1, s == 0 ? 27'h10 : 27'(s + 1)});
        end
        r = mk(vpmb_pkg::MODE_SYS18, 27'h2, 27'h3);
        r.xBot = 18'h00006;
        r.lowerYOperandBus = 36'h7;
        r.chainEn = 1'b1;
        r.chainIn = 64'h0000_1000_0000_0005;
        send(r, 74'h35, 64, {1'b1, 27'h5});
        r = mk(vpmb_pkg::MODE_SYS27, 27'h7ff_ffff, 27'h7ff_ffff);
        r.chainEn = 1'b1;
        r.chainIn = 64'hffc0_0000_0000_0000;
        t = 64'(27'h7ff_ffff) * 64'(27'h7ff_ffff) + 64'hffc0_0000_0000_0000;
        send(r, 74'(t), 64, {1'b1, 27'h2});
        drain();
    endtask
    // Far side stalls for 60 cycles, checks that the buffer refuses, then drains it to empty
    task automatic t_fill();
        stall = 1'b1;
        fork
            for (int i = 0; i < 20; i++) begin
                send(mk(vpmb_pkg::MODE_27X27, 27'(i), 27'h1), 74'(i), 64, 28'h000_0000);
            end
            begin
                repeat (60) @(negedge clk);
                check("reqReady when full", 74'h0, 74'(reqReady));
                check("resValid when full", 74'h1, 74'(resValid));
                stall = 1'b0;
            end
        join
        drain();
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_indep();
        t_wide();
        t_sums();
        t_sys();
        t_fill();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk);
        $display("ERROR watchdog expected done seen running");
        fails++;
        final_report();
    end
endmodule // testbench
bind vpmb_core vpmb_core_sva i_vpmb_core_sva (.clk(clk), .rst(rst), .reqValid(reqValid), .reqReady(reqReady),
    .req(req), .resValid(resValid), .resReady(resReady), .res(res));
